// file: core/addr_flags_pkg.sv
package addr_flags_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_OPERAND = 8'h08;
  localparam logic [7:0] OFS_INDEX = 8'h0c;
  localparam logic [7:0] OFS_PC = 8'h10;
  localparam logic [7:0] OFS_VALUE = 8'h14;
  localparam logic [7:0] OFS_EA = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  // ----------------------------------------------------------------
  // Condition flag layout and reset values
  // ----------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_I = 3;
  localparam logic [7:0] FLAGS_RESET = 8'h68;
  localparam logic [7:0] FLAGS_FIXED = 8'h60;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ----------------------------------------------------------------
  // Operand modes and operations
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    register_only_mode = 7'h01,
    branch_offset_mode = 7'h02,
    literal_operand_mode = 7'h04,
    zero_page_mode = 7'h08,
    full_address_mode = 7'h10,
    index_pointer_mode = 7'h20,
    index_post_increment_mode = 7'h40
  } mode_type;

  typedef enum logic [2:0] {
    op_load = 3'h0,
    op_add = 3'h1,
    op_sub = 3'h2,
    op_and = 3'h3,
    op_shift = 3'h4,
    op_bit_branch = 3'h5,
    op_branch = 3'h6,
    copy_memory_op = 3'h7
  } op_type;

  typedef struct packed {
    logic cond;
    logic wide;
    op_type op;
    mode_type dst;
    mode_type src;
  } cmd_type;

endpackage : addr_flags_pkg

// file: core/addr_flags_unit.sv
// Functional notes
// - N flag follows bit 7 of arithmetic, logic and manipulation results.
// - Loads and stores set N from the moved value's top bit, 8 or 16 bits.
// - Z flag set when the byte or word result is all zero.
// - Loads and stores set Z when the moved value is all zero.
// - C flag from add carry, subtract borrow, bit test and shift.
// - Memory, registers and I/O share one 64 KB address space.
// - Every mode except register-only yields a 16-bit effective address.
// - Effective address costs no extra cycles.
// - Register-only operations make no operand memory access.
// - Branch offset is a signed byte after the opcode, -128 to +127.
// - Taken branch adds sign-extended offset to PC, else falls through.
// - Literal mode uses instruction bytes as the 8 or 16-bit value.
// - Zero-page address is instruction byte with high byte forced zero.
// - Wide zero-page access: high byte at address, low byte at next.
// - Full-address mode takes a complete 16-bit address from the instruction.
// - Indexed variants use the 16-bit index pair as base.
// - Index-pointer address is index high byte over index low byte.
// - Post-increment mode accesses at index pair then increments it.
// - Test-and-branch fetch operand by mode, then branch relative.
// - Memory copy resolves source and destination by separate modes.
// - Interrupt mask set blocks every maskable interrupt.
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module addr_flags_unit (
  input wire logic i_clock, // 100 MHz clock
  input wire logic i_reset_n, // Synchronous reset, active low
  input wire logic i_hsel, // Slave select
  input wire logic [31:0] i_haddr, // Byte address
  input wire logic [1:0] i_htrans, // Transfer type
  input wire logic i_hwrite, // Write when high
  input wire logic [2:0] i_hsize, // Transfer size
  input wire logic [31:0] i_hwdata, // Write data
  input wire logic i_hready, // Bus ready
  input wire logic i_irq_request, // Maskable interrupt request pin
  output logic [31:0] o_hrdata, // Read data
  output logic o_hreadyout, // Slave ready
  output logic o_hresp, // Always OKAY
  output logic [15:0] o_eff_addr, // Last effective address
  output logic o_mem_access, // Last operation touched memory
  output logic o_irq_accept // Request passed the mask
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  addr_flags_pkg::cmd_type cmd_r;
  logic [23:0] operand_r;
  logic [15:0] index_r;
  logic [15:0] index_nxt;
  logic [15:0] pc_r;
  logic [15:0] pc_nxt;
  logic [31:0] value_r;
  logic [15:0] ea_r;
  logic [15:0] ea2_r;
  logic [15:0] result_r;
  logic access_r;
  logic taken_r;
  logic two_byte_r;
  logic pend_r;
  logic pend_write_r;
  logic [7:0] addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic irq_level_r;
  logic irq_accept_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic take_w = i_hsel & i_hready & (i_htrans == addr_flags_pkg::HTRANS_NONSEQ);
  wire logic wr_w = pend_r & pend_write_r;
  wire logic wr_flags = wr_w & (addr_r == addr_flags_pkg::OFS_FLAGS);
  wire logic wr_cmd = wr_w & (addr_r == addr_flags_pkg::OFS_CMD);
  wire logic wr_operand = wr_w & (addr_r == addr_flags_pkg::OFS_OPERAND);
  wire logic wr_index = wr_w & (addr_r == addr_flags_pkg::OFS_INDEX);
  wire logic wr_pc = wr_w & (addr_r == addr_flags_pkg::OFS_PC);
  wire logic wr_value = wr_w & (addr_r == addr_flags_pkg::OFS_VALUE);

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = addr_flags_pkg::ZERO_WORD;
    unique case (addr_r)
      addr_flags_pkg::OFS_FLAGS: rd_mux = {24'h000000, flags_r};
      addr_flags_pkg::OFS_CMD: rd_mux = {13'h0000, cmd_r};
      addr_flags_pkg::OFS_OPERAND: rd_mux = {8'h00, operand_r};
      addr_flags_pkg::OFS_INDEX: rd_mux = {16'h0000, index_r};
      addr_flags_pkg::OFS_PC: rd_mux = {16'h0000, pc_r};
      addr_flags_pkg::OFS_VALUE: rd_mux = value_r;
      addr_flags_pkg::OFS_EA: rd_mux = {ea2_r, ea_r};
      addr_flags_pkg::OFS_STATUS: rd_mux = {13'h0000, two_byte_r, taken_r, access_r, result_r};
      default: rd_mux = addr_flags_pkg::ZERO_WORD;
    endcase
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire addr_flags_pkg::cmd_type cmd_w = addr_flags_pkg::cmd_type'(i_hwdata[18:0]);
  wire addr_flags_pkg::mode_type src_w = cmd_w.src;
  wire addr_flags_pkg::mode_type dst_w = cmd_w.dst;
  wire addr_flags_pkg::op_type op_w = cmd_w.op;
  wire logic [7:0] b1 = operand_r[7:0];
  wire logic [7:0] b2 = operand_r[15:8];
  wire logic [7:0] b3 = operand_r[23:16];
  wire logic is_bit_op = (op_w == addr_flags_pkg::op_bit_branch);
  wire logic is_copy = (op_w == addr_flags_pkg::copy_memory_op);
  wire logic src_inc = (src_w == addr_flags_pkg::index_post_increment_mode);
  wire logic dst_inc = is_copy & (dst_w == addr_flags_pkg::index_post_increment_mode);

  // The bit-test form carries its zero-page byte first, so its offset moves
  // to the second byte.
  wire logic [7:0] offset_w = is_bit_op ? b2 : b1;
  wire logic [15:0] target_w = pc_r + {{8{offset_w[7]}}, offset_w};
  // A copy from the post-increment index pair puts its zero-page destination in byte one.
  wire logic [7:0] dst_byte = src_inc ? b1 : b2;

  function automatic logic [15:0] ea_of(
    input addr_flags_pkg::mode_type m,
    input logic [7:0] zp,
    input logic [15:0] full,
    input logic [15:0] idx,
    input logic [15:0] pc,
    input logic [15:0] tgt
  );
    logic [15:0] ea;
    ea = 16'h0000;
    case (m)
      addr_flags_pkg::branch_offset_mode: ea = tgt;
      addr_flags_pkg::literal_operand_mode: ea = pc;
      addr_flags_pkg::zero_page_mode: ea = {8'h00, zp};
      addr_flags_pkg::full_address_mode: ea = full;
      addr_flags_pkg::index_pointer_mode: ea = idx;
      addr_flags_pkg::index_post_increment_mode: ea = idx;
      default: ea = 16'h0000;
    endcase
    return ea;
  endfunction : ea_of

  wire logic [15:0] src_ea = ea_of(src_w, b1, {b1, b2}, index_r, pc_r, target_w);
  wire logic [15:0] dst_ea = ea_of(dst_w, dst_byte, {b2, b3}, index_r, pc_r, target_w);
  wire logic access_w = (src_w != addr_flags_pkg::register_only_mode);
  wire logic two_w = cmd_w.wide & access_w & (src_w != addr_flags_pkg::literal_operand_mode);
  // Wide accesses read the high byte at the address and the low byte after it.
  wire logic [15:0] ea2_w = is_copy ? dst_ea : (two_w ? src_ea + 16'h0001 : 16'h0000);

  // ----------------------------------------------------------------
  // Operand fetch and result flags
  // ----------------------------------------------------------------
  wire logic lit_w = (src_w == addr_flags_pkg::literal_operand_mode);
  wire logic [15:0] lit_val = cmd_w.wide ? {b1, b2} : {8'h00, b1};
  wire logic [15:0] mem_val = cmd_w.wide ? value_r[31:16] : {8'h00, value_r[15:8]};
  wire logic [15:0] opnd_w = lit_w ? lit_val : mem_val;
  wire logic [7:0] acc_w = value_r[7:0];
  wire logic [8:0] sum_w = {1'b0, acc_w} + {1'b0, opnd_w[7:0]};
  wire logic [8:0] dif_w = {1'b0, acc_w} - {1'b0, opnd_w[7:0]};
  wire logic tbit_w = opnd_w[b3[2:0]];
  wire logic wide_res = cmd_w.wide & ((op_w == addr_flags_pkg::op_load) | is_copy);

  logic [15:0] res_w;
  logic carry_w;
  always_comb
  begin
    res_w = opnd_w;
    carry_w = flags_r[addr_flags_pkg::FLAG_C];
    unique case (op_w)
      addr_flags_pkg::op_load: res_w = opnd_w;
      addr_flags_pkg::op_add:
      begin
        res_w = {8'h00, sum_w[7:0]};
        carry_w = sum_w[8];
      end
      addr_flags_pkg::op_sub:
      begin
        res_w = {8'h00, dif_w[7:0]};
        carry_w = dif_w[8];
      end
      addr_flags_pkg::op_and: res_w = {8'h00, acc_w & opnd_w[7:0]};
      addr_flags_pkg::op_shift:
      begin
        res_w = {8'h00, opnd_w[6:0], 1'b0};
        carry_w = opnd_w[7];
      end
      addr_flags_pkg::op_bit_branch: carry_w = tbit_w;
      addr_flags_pkg::op_branch: res_w = opnd_w;
      addr_flags_pkg::copy_memory_op: res_w = opnd_w;
    endcase
  end

  wire logic neg_w = wide_res ? res_w[15] : res_w[7];
  wire logic zero_w = wide_res ? (res_w == 16'h0000) : (res_w[7:0] == 8'h00);
  wire logic nz_upd = ~is_bit_op & (op_w != addr_flags_pkg::op_branch);
  wire logic taken_w = ((op_w == addr_flags_pkg::op_branch) & cmd_w.cond) |
                       (is_bit_op & (tbit_w == cmd_w.cond));

  always_comb
  begin
    flags_nxt = flags_r;
    if (wr_flags)
    begin
      flags_nxt = i_hwdata[7:0];
    end
    else if (wr_cmd)
    begin
      if (nz_upd)
      begin
        flags_nxt[addr_flags_pkg::FLAG_N] = neg_w;
        flags_nxt[addr_flags_pkg::FLAG_Z] = zero_w;
      end
      flags_nxt[addr_flags_pkg::FLAG_C] = carry_w;
    end
    flags_nxt = flags_nxt | addr_flags_pkg::FLAGS_FIXED;
  end

  // The step is a plain 16-bit add, so the low-byte carry reaches the
  // high byte and the pair wraps at the top of the map.
  always_comb
  begin
    index_nxt = index_r;
    if (wr_index)
    begin
      index_nxt = i_hwdata[15:0];
    end
    else if (wr_cmd & (src_inc | dst_inc))
    begin
      index_nxt = index_r + 16'h0001;
    end
  end

  always_comb
  begin
    pc_nxt = pc_r;
    if (wr_pc)
    begin
      pc_nxt = i_hwdata[15:0];
    end
    else if (wr_cmd & taken_w)
    begin
      pc_nxt = target_w;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Every transfer takes one wait state; the read mux then sees any write
  // that finished just before it.
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      pend_r <= 1'b0;
      pend_write_r <= 1'b0;
      addr_r <= 8'h00;
      hrdata_r <= addr_flags_pkg::ZERO_WORD;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
    else if (pend_r)
    begin
      pend_r <= 1'b0;
      hreadyout_r <= 1'b1;
      hrdata_r <= pend_write_r ? addr_flags_pkg::ZERO_WORD : rd_mux;
    end
    else if (take_w)
    begin
      pend_r <= 1'b1;
      pend_write_r <= i_hwrite;
      addr_r <= i_haddr[7:0];
      hreadyout_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Execution state
  // ----------------------------------------------------------------
  // One flat space: a single address output serves memory, registers and I/O.
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      flags_r <= addr_flags_pkg::FLAGS_RESET;
      cmd_r <= '0;
      operand_r <= 24'h000000;
      index_r <= 16'h0000;
      pc_r <= 16'h0000;
      value_r <= addr_flags_pkg::ZERO_WORD;
      ea_r <= 16'h0000;
      ea2_r <= 16'h0000;
      result_r <= 16'h0000;
      access_r <= 1'b0;
      taken_r <= 1'b0;
      two_byte_r <= 1'b0;
    end
    else
    begin
      flags_r <= flags_nxt;
      index_r <= index_nxt;
      pc_r <= pc_nxt;
      if (wr_operand)
      begin
        operand_r <= i_hwdata[23:0];
      end
      if (wr_value)
      begin
        value_r <= i_hwdata;
      end
      if (wr_cmd)
      begin
        cmd_r <= cmd_w;
        ea_r <= access_w ? src_ea : 16'h0000;
        ea2_r <= ea2_w;
        result_r <= res_w;
        access_r <= access_w;
        taken_r <= taken_w;
        two_byte_r <= two_w;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request path
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      irq_level_r <= 1'b0;
      irq_accept_r <= 1'b0;
    end
    else
    begin
      sync1_r <= i_irq_request;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r)
      begin
        irq_level_r <= sync3_r;
      end
      irq_accept_r <= irq_level_r & ~flags_r[addr_flags_pkg::FLAG_I];
    end
  end

  assign o_hrdata = hrdata_r;
  assign o_hreadyout = hreadyout_r;
  assign o_hresp = hresp_r;
  assign o_eff_addr = ea_r;
  assign o_mem_access = access_r;
  assign o_irq_accept = irq_accept_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_flags_n;
    @(posedge i_clock) disable iff (!i_reset_n)
    wr_cmd & nz_upd |=> flags_r[addr_flags_pkg::FLAG_N] == $past(neg_w);
  endproperty
  a_flags_n: assert property (p_flags_n) else $error("N flag wrong");

  property p_flags_z;
    @(posedge i_clock) disable iff (!i_reset_n)
    wr_cmd & nz_upd & ~wide_res |=>
      flags_r[addr_flags_pkg::FLAG_Z] == ($past(res_w[7:0]) == 8'h00);
  endproperty
  a_flags_z: assert property (p_flags_z) else $error("Z flag wrong");

  property p_add_carry;
    @(posedge i_clock) disable iff (!i_reset_n)
    wr_cmd & (op_w == addr_flags_pkg::op_add) |=>
      flags_r[addr_flags_pkg::FLAG_C] == $past(sum_w[8]);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("carry wrong");

  property p_ea_timing;
    @(posedge i_clock) disable iff (!i_reset_n)
    wr_cmd & access_w |=> o_eff_addr == $past(src_ea);
  endproperty
  a_ea_timing: assert property (p_ea_timing) else $error("address late");

  property p_no_access;
    @(posedge i_clock) disable iff (!i_reset_n)
    wr_cmd & (src_w == addr_flags_pkg::register_only_mode) |=> !o_mem_access && o_eff_addr == 16'h0000;
  endproperty
  a_no_access: assert property (p_no_access) else $error("inherent accessed");

  property p_zero_page;
    @(posedge i_clock) disable iff (!i_reset_n)
    wr_cmd & (src_w == addr_flags_pkg::zero_page_mode) |=> o_eff_addr[15:8] == 8'h00;
  endproperty
  a_zero_page: assert property (p_zero_page) else $error("page not zero");

  property p_post_inc;
    @(posedge i_clock) disable iff (!i_reset_n)
    wr_cmd & src_inc |=> index_r == $past(index_r) + 16'h0001 && o_eff_addr == $past(index_r);
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post increment wrong");

  property p_branch;
    @(posedge i_clock) disable iff (!i_reset_n)
    wr_cmd & (op_w == addr_flags_pkg::op_branch) |=>
      pc_r == ($past(cmd_w.cond) ? $past(pc_r) + {{8{$past(b1[7])}}, $past(b1)} : $past(pc_r));
  endproperty
  a_branch: assert property (p_branch) else $error("branch target wrong");

  property p_irq_mask;
    @(posedge i_clock) disable iff (!i_reset_n)
    flags_r[addr_flags_pkg::FLAG_I] |=> !o_irq_accept;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked request passed");

endmodule : addr_flags_unit

`default_nettype wire

// file: test/cpu_address_mode_and_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none

module cpu_address_mode_and_flags_tb;

  // ----------------------------------------------------------------
  // Signals and scoreboard
  // ----------------------------------------------------------------
  logic i_clock;
  logic i_reset_n;
  logic i_hsel;
  logic [31:0] i_haddr;
  logic [1:0] i_htrans;
  logic i_hwrite;
  logic [2:0] i_hsize;
  logic [31:0] i_hwdata;
  logic i_irq_request;
  logic [31:0] o_hrdata;
  logic o_hreadyout;
  logic o_hresp;
  logic [15:0] o_eff_addr;
  logic o_mem_access;
  logic o_irq_accept;
  int err_count;
  int checked;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic rd_pend = 1'b0;

  addr_flags_unit dut_u (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hsize(i_hsize),
    .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout),
    .i_irq_request(i_irq_request),
    .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_eff_addr(o_eff_addr),
    .o_mem_access(o_mem_access),
    .o_irq_accept(o_irq_accept)
  );

  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    // A read whose answer never arrived is a mismatch as well.
    err_count += exp_q.size();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  // The monitor samples before the design's updates land, so the data phase of a read
  // ends at the first edge where the slave was ready again.
  always @(posedge i_clock)
  begin
    if (rd_pend && o_hreadyout === 1'b1)
    begin
      chk(o_hrdata & msk_q.pop_front(), exp_q.pop_front());
      rd_pend = 1'b0;
    end
    if (i_reset_n && i_hsel && o_hreadyout === 1'b1 && i_htrans == 2'h2 && !i_hwrite)
      rd_pend = 1'b1;
  end

  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge i_clock);
      n++;
    end
    while (o_hreadyout !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      err_count++;
      conclude();
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                     input logic [31:0] exp, input logic [31:0] msk);
    i_hsel <= 1'b1;
    i_htrans <= addr_flags_pkg::HTRANS_NONSEQ;
    i_haddr <= {24'h000000, ofs};
    i_hwrite <= wr;
    if (!wr)
    begin
      exp_q.push_back(exp & msk);
      msk_q.push_back(msk);
    end
    wait_ready();
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    wait_ready();
  endtask : bus

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    bus(1'b1, ofs, d, 32'h0, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] ofs, input logic [31:0] e,
                    input logic [31:0] m = 32'hffffffff);
    bus(1'b0, ofs, 32'h0, e, m);
  endtask : rd

  function automatic logic [31:0] cmd(input int s, input int d, input int op,
                                      input logic w, input logic c);
    addr_flags_pkg::cmd_type k;
    k.src = addr_flags_pkg::mode_type'(7'h01 << s);
    k.dst = addr_flags_pkg::mode_type'(7'h01 << d);
    k.op = addr_flags_pkg::op_type'(op);
    k.wide = w;
    k.cond = c;
    return {13'h0000, k};
  endfunction : cmd

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin : main
    logic [15:0] pc;
    logic [15:0] idx;
    logic [15:0] ea;
    logic [23:0] opnd;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] r;
    logic c;
    {i_reset_n, i_hsel, i_hwrite, i_irq_request} = 4'h0;
    {i_haddr, i_hwdata, i_htrans} = 66'h0;
    i_hsize = 3'h2;
    err_count = 0;
    checked = 0;
    void'($urandom(32'hf2613ef0));
    repeat (6) @(posedge i_clock);
    i_reset_n <= 1'b1;
    i_irq_request <= 1'b1;
    rd(addr_flags_pkg::OFS_FLAGS, 32'h68);
    rd(addr_flags_pkg::OFS_EA, 32'h0);
    rd(8'h20, 32'h0);
    chk({31'h0, o_irq_accept}, 32'h0);
    wr(addr_flags_pkg::OFS_FLAGS, 32'h0);
    rd(addr_flags_pkg::OFS_FLAGS, 32'h60);
    for (int n = 0; n < 20 && o_irq_accept !== 1'b1; n++) @(posedge i_clock);
    chk({31'h0, o_irq_accept}, 32'h1);
    wr(addr_flags_pkg::OFS_FLAGS, 32'h8);
    repeat (3) @(posedge i_clock);
    chk({31'h0, o_irq_accept}, 32'h0);
    // Every mode in turn; the last index base sits at the top so the increment must wrap.
    for (int i = 0; i < 7; i++)
    begin
      pc = 16'($urandom);
      idx = (i == 6) ? 16'hffff : 16'($urandom);
      opnd = 24'($urandom);
      wr(addr_flags_pkg::OFS_PC, {16'h0, pc});
      wr(addr_flags_pkg::OFS_INDEX, {16'h0, idx});
      wr(addr_flags_pkg::OFS_OPERAND, {8'h0, opnd});
      wr(addr_flags_pkg::OFS_CMD, cmd(i, 0, 0, 1'b0, 1'b0));
      case (i)
        0: ea = 16'h0000;
        1: ea = pc + {{8{opnd[7]}}, opnd[7:0]};
        2: ea = pc;
        3: ea = {8'h00, opnd[7:0]};
        4: ea = {opnd[7:0], opnd[15:8]};
        default: ea = idx;
      endcase
      chk({16'h0, o_eff_addr}, {16'h0, ea});
      chk({31'h0, o_mem_access}, {31'h0, i != 0});
      rd(addr_flags_pkg::OFS_EA, {16'h0, ea}, 32'hffff);
      rd(addr_flags_pkg::OFS_INDEX, {16'h0, idx + 16'(i == 6)});
    end
    for (int k = 0; k < 2; k++)
    begin
      pc = 16'($urandom);
      b = k ? 8'h80 : 8'h7f;
      wr(addr_flags_pkg::OFS_PC, {16'h0, pc});
      wr(addr_flags_pkg::OFS_OPERAND, {24'h0, b});
      wr(addr_flags_pkg::OFS_CMD, cmd(1, 0, 6, 1'b0, k[0]));
      rd(addr_flags_pkg::OFS_PC, {16'h0, k ? pc + {{8{b[7]}}, b} : pc});
      rd(addr_flags_pkg::OFS_STATUS, {14'h0, k[0], 17'h0}, 32'h20000);
    end
    // Boundary operands first, random ones after; C is compared only where it is defined.
    for (int i = 0; i < 8; i++)
    begin
      a = (i < 4) ? ((i == 0) ? 8'hff : 8'h00) : 8'($urandom);
      b = (i < 4) ? ((i == 0) ? 8'h01 : 8'h80) : 8'($urandom);
      wr(addr_flags_pkg::OFS_FLAGS, 32'h0);
      wr(addr_flags_pkg::OFS_VALUE, {24'h0, a});
      wr(addr_flags_pkg::OFS_OPERAND, {24'h0, b});
      wr(addr_flags_pkg::OFS_CMD, cmd(2, 0, (i + 1) % 4, 1'b0, 1'b0));
      case (i % 4)
        0: {c, r} = {1'b0, a} + {1'b0, b};
        1: {c, r} = {1'b0, a} - {1'b0, b};
        2: {c, r} = {1'b0, a & b};
        default: {c, r} = {1'b0, b};
      endcase
      rd(addr_flags_pkg::OFS_FLAGS, {29'h0, r[7], r == 8'h00, c},
         (i % 4 < 2) ? 32'h7 : 32'h6);
      rd(addr_flags_pkg::OFS_STATUS, {24'h0, r}, 32'hff);
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(addr_flags_pkg::OFS_FLAGS, 32'h0);
      wr(addr_flags_pkg::OFS_OPERAND, k ? 32'h0 : 32'h8080);
      wr(addr_flags_pkg::OFS_CMD, cmd(2, 0, 0, 1'b1, 1'b0));
      rd(addr_flags_pkg::OFS_FLAGS, {29'h0, k == 0, k == 1, 1'b0}, 32'h6);
    end
    // Shift left: the top bit leaves through C, the rest moves up one place.
    for (int k = 0; k < 2; k++)
    begin
      b = {k[0], 7'($urandom)};
      wr(addr_flags_pkg::OFS_FLAGS, 32'h0);
      wr(addr_flags_pkg::OFS_OPERAND, {24'h0, b});
      wr(addr_flags_pkg::OFS_CMD, cmd(2, 0, 4, 1'b0, 1'b0));
      rd(addr_flags_pkg::OFS_FLAGS, {29'h0, b[6], b[6:0] == 7'h00, b[7]},
         32'h7);
      rd(addr_flags_pkg::OFS_STATUS, {24'h0, b[6:0], 1'b0}, 32'hff);
    end
    // Every pairing of tested bit and wanted level, so the branch goes both ways.
    for (int k = 0; k < 4; k++)
    begin
      pc = 16'($urandom);
      opnd = 24'($urandom);
      a = 8'($urandom);
      a[opnd[18:16]] = k[1];
      wr(addr_flags_pkg::OFS_FLAGS, 32'h0);
      wr(addr_flags_pkg::OFS_PC, {16'h0, pc});
      wr(addr_flags_pkg::OFS_VALUE, {16'h0, a, 8'h00});
      wr(addr_flags_pkg::OFS_OPERAND, {8'h0, opnd});
      wr(addr_flags_pkg::OFS_CMD, cmd(3, 0, 5, 1'b0, k[0]));
      ea = (k[1] == k[0]) ? pc + {{8{opnd[15]}}, opnd[15:8]} : pc;
      rd(addr_flags_pkg::OFS_PC, {16'h0, ea});
      rd(addr_flags_pkg::OFS_FLAGS, {31'h0, k[1]}, 32'h7);
      rd(addr_flags_pkg::OFS_EA, {24'h0, opnd[7:0]});
    end
    // Copies from and to the index pair must both step it exactly once.
    for (int j = 0; j < 2; j++)
    begin
      idx = 16'($urandom);
      opnd = 24'($urandom);
      wr(addr_flags_pkg::OFS_INDEX, {16'h0, idx});
      wr(addr_flags_pkg::OFS_OPERAND, {8'h0, opnd});
      wr(addr_flags_pkg::OFS_CMD, j ? cmd(3, 6, 7, 1'b0, 1'b0) : cmd(6, 3, 7, 1'b0, 1'b0));
      rd(addr_flags_pkg::OFS_EA, j ? {idx, 8'h00, opnd[7:0]} : {8'h00, opnd[7:0], idx});
      rd(addr_flags_pkg::OFS_INDEX, {16'h0, idx + 16'h0001});
    end
    wr(addr_flags_pkg::OFS_OPERAND, 32'h5af0);
    wr(addr_flags_pkg::OFS_CMD, cmd(3, 0, 0, 1'b1, 1'b0));
    rd(addr_flags_pkg::OFS_EA, 32'h00f1_00f0);
    wr(addr_flags_pkg::OFS_CMD, cmd(3, 3, 7, 1'b0, 1'b0));
    wr(addr_flags_pkg::OFS_EA, 32'hffffffff);
    rd(addr_flags_pkg::OFS_EA, 32'h005a_00f0);
    // One more edge lets the monitor compare the last read before the verdict.
    @(posedge i_clock);
    conclude();
  end

endmodule : cpu_address_mode_and_flags_tb

`default_nettype wire
